//--- hw/mpcd_top.sv
// Multiphase clock divider: prescaler, strap capture, phase generator and
// pseudorandom downspread source for the modulation converter.
// Assumes clk is the master oscillator; straps are decoded three-level codes.
// The divide-by-one two-phase case puts clk itself on the pins; all else is flops.
`timescale 1ns/1ps
`include "mpcd_defines.svh"

// Functional notes
// - Prescaler divides by 1, 10 or 100
// - Two-phase divide-by-one forwards master clock unchanged
// - Lane select: 2, 3 or 4 phases
// - Prescaler steps generator; lanes drive pins
// - Output rate is master over N times M
// - Three/four phase divide further, mode duty
// - Grounded spread input stops modulation logic
// - Modulation only lowers frequency below maximum
// - Two-phase: inverse pair, half duty, copied
// - Three-phase: shift register, third duty, lag
// - Four-phase: flops, half duty, quarter lag
// - Nine-bit sequence, master/3200, 512 steps
module mpcd_top
    import mpcd_pkg::*;
#(
    // Divide factors per prescale strap code; each must fit the prescale counter
    parameter logic [6:0] PRE_LOW = `MPCD_PRE_LOW,
    parameter logic [6:0] PRE_OPEN = `MPCD_PRE_OPEN,
    parameter logic [6:0] PRE_HIGH = `MPCD_PRE_HIGH,
    // Master cycles per sequence step; limited by the 12-bit step counter
    parameter logic [11:0] STEP_DIV = `MPCD_STEP_DIV
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire mpcd_tri_t div_select_code,
    input wire mpcd_tri_t lane_count_select,
    input wire logic spread_amount_grounded,
    output logic phase_output_1,
    output logic phase_output_2,
    output logic phase_output_3,
    output logic phase_output_4,
    output logic spread_spectrum_modulation,
    output logic [6:0] spread_dac_code
);

    mpcd_top_state_t st_r;
    mpcd_top_state_t st_nxt;
    logic [6:0] pre_factor;
    logic [3:0] phases;
    logic pass_clk;
    logic lfsr_taps;
    logic lfsr_fill;
    logic lfsr_fb;
    logic div_is_low;
    logic lane_is_low;

    ////////////////////////////////////////////////////////////////////////////
    // strap to divide factor
    // An unknown code falls back to the fastest setting rather than stalling
    always_comb
    begin
        unique case (st_r.div_sel)
            MPCD_TRI_LOW: pre_factor = PRE_LOW;
            MPCD_TRI_OPEN: pre_factor = PRE_OPEN;
            MPCD_TRI_HIGH: pre_factor = PRE_HIGH;
            default: pre_factor = PRE_LOW;
        endcase
    end

    assign lfsr_taps = st_r.lfsr[`MPCD_LFSR_TAP_HI] ^ st_r.lfsr[`MPCD_LFSR_TAP_LO];
    // The zero-fill term splices the all-zero state into the maximal loop,
    // so any seed works and the loop still holds 512 states
    assign lfsr_fill = (st_r.lfsr[`MPCD_LFSR_TAP_HI-1:0] == `MPCD_LFSR_LOW_ZERO);
    assign lfsr_fb = lfsr_taps ^ lfsr_fill;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt = st_r;
        // three-flop strap capture
        // A level is adopted only once stages two and three agree, so a pin
        // caught mid-swing never reaches the mode decode
        st_nxt.div_s1 = div_select_code;
        st_nxt.div_s2 = st_r.div_s1;
        st_nxt.div_s3 = st_r.div_s2;
        if (st_r.div_s2 == st_r.div_s3)
        begin
            st_nxt.div_sel = st_r.div_s3;
        end
        st_nxt.lane_s1 = lane_count_select;
        st_nxt.lane_s2 = st_r.lane_s1;
        st_nxt.lane_s3 = st_r.lane_s2;
        if (st_r.lane_s2 == st_r.lane_s3)
        begin
            st_nxt.lane_sel = st_r.lane_s3;
        end

        st_nxt.gnd_s[0] = spread_amount_grounded;
        st_nxt.gnd_s[1] = st_r.gnd_s[0];
        st_nxt.gnd_s[2] = st_r.gnd_s[1];
        if (st_r.gnd_s[1] == st_r.gnd_s[2])
        begin
            st_nxt.gnd = st_r.gnd_s[2];
        end

        // prescaler step every N
        // The count wraps at factor minus one; a factor of one ticks every cycle
        if (st_r.pre_cnt + `MPCD_PRE_ONE >= pre_factor)
        begin
            st_nxt.pre_cnt = `MPCD_PRE_ZERO;
        end
        else
        begin
            st_nxt.pre_cnt = st_r.pre_cnt + `MPCD_PRE_ONE;
        end
        st_nxt.tick = (st_nxt.pre_cnt == `MPCD_PRE_ZERO);
        st_nxt.half = (st_nxt.pre_cnt < (pre_factor >> 1));

        // grounded input parks modulation
        // Parking reseeds the sequence so every enable starts from one point
        if (st_r.gnd)
        begin
            st_nxt.step_cnt = `MPCD_STEP_ZERO;
            st_nxt.lfsr = `MPCD_LFSR_SEED;
            st_nxt.dac = `MPCD_DAC_ZERO;
            st_nxt.mod_en = 1'b0;
        end
        else
        begin
            st_nxt.mod_en = 1'b1;
            if (st_r.step_cnt + `MPCD_STEP_ONE >= STEP_DIV)
            begin
                st_nxt.step_cnt = `MPCD_STEP_ZERO;
                st_nxt.lfsr = {st_r.lfsr[7:0], lfsr_fb};
            end
            else
            begin
                st_nxt.step_cnt = st_r.step_cnt + `MPCD_STEP_ONE;
            end
            // code only subtracts from the maximum
            // Code zero means no pull-down; larger codes only lower the rate
            st_nxt.dac = st_r.lfsr[`MPCD_DAC_W-1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            // The lane strap reads as unset until captured: lanes stay low and
            // the clock pass-through stays shut instead of guessing a mode
            st_r <= '{
                div_s1: MPCD_TRI_LOW,
                div_s2: MPCD_TRI_LOW,
                div_s3: MPCD_TRI_LOW,
                div_sel: MPCD_TRI_LOW,
                lane_s1: mpcd_tri_t'(`MPCD_TRI_UNSET),
                lane_s2: mpcd_tri_t'(`MPCD_TRI_UNSET),
                lane_s3: mpcd_tri_t'(`MPCD_TRI_UNSET),
                lane_sel: mpcd_tri_t'(`MPCD_TRI_UNSET),
                gnd_s: `MPCD_GND_SYNC_INIT,
                gnd: 1'b1,
                pre_cnt: `MPCD_PRE_ZERO,
                tick: 1'b0,
                half: 1'b0,
                step_cnt: `MPCD_STEP_ZERO,
                lfsr: `MPCD_LFSR_SEED,
                dac: `MPCD_DAC_ZERO,
                mod_en: 1'b0
            };
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // prescaler steps the generator
    mpcd_phase_gen u_phase_gen (
        .clk(clk),
        .nrst(nrst),
        .lane_mode(st_r.lane_sel),
        .step(st_r.tick),
        .half(st_r.half),
        .phases(phases)
    );

    // divide-by-one two-phase forwards clk
    // Flops cannot toggle at the clock rate, so this one case passes clk itself
    // Shut in reset and while the lane strap is still unset
    assign div_is_low = (st_r.div_sel == MPCD_TRI_LOW);
    assign lane_is_low = (st_r.lane_sel == MPCD_TRI_LOW);
    assign pass_clk = nrst && div_is_low && lane_is_low;

    // inverse pair from the same source
    // Both halves of each pair pass one mux level, keeping their edges
    // matched; an inverter after the first lane would skew the second
    always_comb
    begin
        if (pass_clk)
        begin
            phase_output_1 = clk;
            phase_output_2 = ~clk;
            phase_output_3 = clk;
            phase_output_4 = ~clk;
        end
        else
        begin
            phase_output_1 = phases[0];
            phase_output_2 = phases[1];
            phase_output_3 = phases[2];
            phase_output_4 = phases[3];
        end
    end
    assign spread_spectrum_modulation = st_r.mod_en;
    assign spread_dac_code = st_r.dac;

endmodule

//--- hw/mpcd_defines.svh
// Constants for the multiphase clock divider: factors, counts, reset values.
// Assumes inclusion by bare name from the design files.
`ifndef MPCD_DEFINES_SVH
`define MPCD_DEFINES_SVH

`define MPCD_PRE_W 7
`define MPCD_PRE_LOW 7'd1
`define MPCD_PRE_OPEN 7'd10
`define MPCD_PRE_HIGH 7'd100
`define MPCD_PRE_ZERO 7'd0
`define MPCD_PRE_ONE 7'd1

`define MPCD_LFSR_W 9
`define MPCD_LFSR_SEED 9'h001
`define MPCD_LFSR_TAP_HI 8
`define MPCD_LFSR_TAP_LO 4
`define MPCD_DAC_W 7
`define MPCD_DAC_ZERO 7'h00
`define MPCD_LFSR_LOW_ZERO 8'h00
`define MPCD_GND_SYNC_INIT 3'h7
`define MPCD_TRI_UNSET 2'h3

`define MPCD_STEP_W 12
`define MPCD_STEP_DIV 12'd3200
`define MPCD_STEP_ZERO 12'd0
`define MPCD_STEP_ONE 12'd1

`define MPCD_RING_W 4
`define MPCD_RING3_INIT 4'h1
`define MPCD_RING4_INIT 4'h3
`define MPCD_RING_ZERO 4'h0

`endif

//--- hw/mpcd_pkg.sv
// Types shared by the multiphase clock divider files.
// Assumes strap levels arrive already decoded into low, open or high codes.
package mpcd_pkg;

    typedef enum logic [1:0] {
        MPCD_TRI_LOW = 2'h0,
        MPCD_TRI_OPEN = 2'h1,
        MPCD_TRI_HIGH = 2'h2
    } mpcd_tri_t;

    typedef struct packed {
        mpcd_tri_t mode;
        logic [3:0] ring;
        logic [3:0] ph;
    } mpcd_pg_state_t;

    typedef struct packed {
        mpcd_tri_t div_s1;
        mpcd_tri_t div_s2;
        mpcd_tri_t div_s3;
        mpcd_tri_t div_sel;
        mpcd_tri_t lane_s1;
        mpcd_tri_t lane_s2;
        mpcd_tri_t lane_s3;
        mpcd_tri_t lane_sel;
        logic [2:0] gnd_s;
        logic gnd;
        logic [6:0] pre_cnt;
        logic tick;
        logic half;
        logic [11:0] step_cnt;
        logic [8:0] lfsr;
        logic [6:0] dac;
        logic mod_en;
    } mpcd_top_state_t;

endpackage

//--- hw/mpcd_phase_gen.sv
// Multiphase generator: turns prescaler steps into 2-, 3- or 4-phase lanes.
// Assumes step and half come from flops on the same clock.
`timescale 1ns/1ps
`include "mpcd_defines.svh"

module mpcd_phase_gen
    import mpcd_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire mpcd_tri_t lane_mode,
    input wire logic step,
    input wire logic half,
    output logic [3:0] phases
);

    mpcd_pg_state_t st_r;
    mpcd_pg_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.mode = lane_mode;
        if (lane_mode != st_r.mode)
        begin
            // Restart the ring so a new mode never starts from a foreign pattern
            st_nxt.ring = (lane_mode == MPCD_TRI_HIGH) ? `MPCD_RING4_INIT : `MPCD_RING3_INIT;
        end
        else if (step)
        begin
            unique case (lane_mode)
                MPCD_TRI_OPEN: st_nxt.ring = {1'b0, st_r.ring[1:0], st_r.ring[2]};
                MPCD_TRI_HIGH: st_nxt.ring = {st_r.ring[2:0], st_r.ring[3]};
                default: st_nxt.ring = st_r.ring;
            endcase
        end
        unique case (st_r.mode)
            MPCD_TRI_LOW: st_nxt.ph = {~half, half, ~half, half};
            MPCD_TRI_OPEN: st_nxt.ph = {1'b0, st_r.ring[2:0]};
            MPCD_TRI_HIGH: st_nxt.ph = st_r.ring;
            default: st_nxt.ph = `MPCD_RING_ZERO;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            // Unset mode keeps every lane low until the strap is known
            st_r.mode <= mpcd_tri_t'(`MPCD_TRI_UNSET);
            st_r.ring <= `MPCD_RING_ZERO;
            st_r.ph <= `MPCD_RING_ZERO;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign phases = st_r.ph;

endmodule

//--- testbench/mpcd_load_model.sv
// Load clocked by one phase lane: reports its period and high time in clk cycles.
// Assumes the lane only moves just after rising clk edges.
`timescale 1ns/1ps
module mpcd_load_model (
    input wire logic clk,
    input wire logic lane,
    output logic [15:0] period,
    output logic [15:0] high_time
);
    logic [15:0] cnt_r = 16'h0000;
    logic [15:0] hi_r = 16'h0000;
    logic prev_r = 1'b0;
    // Measured rise to rise, so a lane change mid-period spoils at most two results
    always @(posedge clk)
    begin
        prev_r <= lane;
        cnt_r <= cnt_r + 16'h0001;
        hi_r <= hi_r + {15'h0000, lane};
        if (lane && !prev_r)
        begin
            period <= cnt_r;
            high_time <= hi_r;
            cnt_r <= 16'h0001;
            hi_r <= 16'h0001;
        end
    end
endmodule

//--- testbench/mpcd_top_assertions.sv
// Checker on the divider top ports: lane shapes, reset and spread enable.
// Assumes straps change only while nrst is low.
`timescale 1ns/1ps
module mpcd_top_assertions
    import mpcd_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire mpcd_tri_t div_select_code,
    input wire mpcd_tri_t lane_count_select,
    input wire logic spread_amount_grounded,
    input wire logic phase_output_1,
    input wire logic phase_output_2,
    input wire logic phase_output_3,
    input wire logic phase_output_4,
    input wire logic spread_spectrum_modulation,
    input wire logic [6:0] spread_dac_code
);
    logic [5:0] up_r;
    // Lane checks wait for strap sync and ring start to be long over
    wire logic ok = up_r == 6'h3f;
    always_ff @(posedge clk)
        up_r <= !nrst ? 6'h00 : up_r + {5'h00, !ok};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence ten_cycle;
        phase_output_1 [*5] ##1 !phase_output_1 [*5] ##1 phase_output_1;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_reset_quiet: assert property (disable iff (1'b0)
        !nrst |=> !(phase_output_1 || phase_output_2 || spread_spectrum_modulation))
        else $error("output active in reset");
    a_ground_stops: assert property ($rose(spread_amount_grounded)
        |-> ##[1:8] !spread_spectrum_modulation) else $error("spread kept running");
    a_spread_starts: assert property ($fell(spread_amount_grounded)
        |-> ##[1:8] spread_spectrum_modulation) else $error("spread not started");
    a_dac_idle: assert property (!spread_spectrum_modulation [*3]
        |-> spread_dac_code == 7'h00) else $error("dac code while idle");
    a_two_phase: assert property (ok && lane_count_select == MPCD_TRI_LOW
        |-> phase_output_2 == !phase_output_1 && phase_output_3 == phase_output_1
        && phase_output_4 == phase_output_2) else $error("two-phase pair wrong");
    a_three_phase: assert property (ok && lane_count_select == MPCD_TRI_OPEN
        && $rose(phase_output_2) |-> $fell(phase_output_1) && !phase_output_3
        && !phase_output_4) else $error("three-phase lag wrong");
    a_four_phase: assert property (ok && lane_count_select == MPCD_TRI_HIGH
        && $rose(phase_output_2) |-> phase_output_1 && !phase_output_3
        && !phase_output_4) else $error("four-phase lag wrong");
    a_ten_period: assert property (ok && div_select_code == MPCD_TRI_OPEN
        && lane_count_select == MPCD_TRI_LOW && $rose(phase_output_1) |-> ten_cycle)
        else $error("divide by ten wrong");
endmodule

//--- testbench/tb.sv
// Bench for the divider top: lane shapes per strap pair, then the spread source.
// Assumes straps are only moved while reset is held.
`timescale 1ns/1ps
`include "mpcd_defines.svh"
module tb
    import mpcd_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic gnd = 1'b1;
    logic [1:0] pick = 2'h0;
    mpcd_tri_t dv = MPCD_TRI_LOW;
    mpcd_tri_t ln = MPCD_TRI_LOW;
    wire logic [3:0] ph;
    wire logic run;
    wire logic [6:0] dac;
    wire logic [15:0] per;
    wire logic [15:0] hi;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    mpcd_top u_mpcd_top (.clk(clk), .nrst(nrst), .div_select_code(dv), .lane_count_select(ln),
        .spread_amount_grounded(gnd), .phase_output_1(ph[0]), .phase_output_2(ph[1]),
        .phase_output_3(ph[2]), .phase_output_4(ph[3]), .spread_spectrum_modulation(run),
        .spread_dac_code(dac));
    mpcd_load_model u_mpcd_load_model (.clk(clk), .lane(ph[pick]), .period(per),
        .high_time(hi));
    initial
    begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            miscompares++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic setup(input mpcd_tri_t d, input mpcd_tri_t l, input logic g);
        nrst = 1'b0;
        dv = d;
        ln = l;
        gnd = g;
        repeat (6) @(negedge clk);
        check({4'h0, ph, run, dac}, 16'h0000);
        nrst = 1'b1;
        repeat (70) @(negedge clk);
    endtask
    task automatic t_lane(input mpcd_tri_t d, input mpcd_tri_t l, input int p, input int h);
        setup(d, l, 1'b1);
        for (int i = 0; i < ((l == MPCD_TRI_OPEN) ? 3 : 4); i++)
        begin
            pick = i[1:0];
            repeat (2 * p + 4) @(negedge clk);
            check(per, p[15:0]);
            check(hi, h[15:0]);
        end
    endtask
    task automatic t_spread();
        logic [8:0] lfsr;
        int n;
        lfsr = `MPCD_LFSR_SEED;
        setup(MPCD_TRI_OPEN, MPCD_TRI_LOW, 1'b0);
        check({9'h001, dac}, {9'h001, lfsr[6:0]});
        for (int s = 0; s < 3; s++)
        begin
            n = 0;
            while (dac === lfsr[6:0] && n < 4000)
            begin
                @(negedge clk);
                n++;
            end
            lfsr = {lfsr[7:0], lfsr[8] ^ lfsr[4] ^ (lfsr[7:0] == 8'h00)};
            check({8'h00, run, dac}, {9'h001, lfsr[6:0]});
            if (s > 0)
                check(n[15:0], 16'h0c80);
        end
        gnd = 1'b1;
        repeat (12) @(negedge clk);
        check({8'h00, run, dac}, 16'h0000);
        gnd = 1'b0;
        repeat (12) @(negedge clk);
    endtask
    initial
    begin
        // every divide and lane pairing that yields flop lanes
        t_lane(MPCD_TRI_OPEN, MPCD_TRI_LOW, 10, 5);
        t_lane(MPCD_TRI_OPEN, MPCD_TRI_OPEN, 30, 10);
        t_lane(MPCD_TRI_OPEN, MPCD_TRI_HIGH, 40, 20);
        t_lane(MPCD_TRI_HIGH, MPCD_TRI_HIGH, 400, 200);
        t_lane(MPCD_TRI_HIGH, MPCD_TRI_LOW, 100, 50);
        t_lane(MPCD_TRI_HIGH, MPCD_TRI_OPEN, 300, 100);
        t_lane(MPCD_TRI_LOW, MPCD_TRI_OPEN, 3, 1);
        t_lane(MPCD_TRI_LOW, MPCD_TRI_HIGH, 4, 2);
        setup(MPCD_TRI_LOW, MPCD_TRI_LOW, 1'b1);
        repeat (2)
        begin
            @(posedge clk);
            #2;
            check({12'h000, ph}, 16'h0005);
            @(negedge clk);
            #2;
            check({12'h000, ph}, 16'h000a);
        end
        @(negedge clk);
        t_spread();
        stop_test();
    end
endmodule

bind mpcd_top mpcd_top_assertions u_mpcd_top_assertions (.*);
